/* File: pkg/syndrome_pkg.sv */
/*
 * constants for the abort syndrome encoder: register map, field positions,
 * fault status codes, walk level codes, access sizes, target levels and the op and fault kinds.
 * assumes a 32-bit apb with byte addresses, one register per aligned word.
 */
package syndrome_pkg;

    // register map, byte addresses
    localparam logic [7:0] FEAT_OFFSET = 8'h00;
    localparam logic [7:0] STAT_OFFSET = 8'h04;
    localparam logic [7:0] LVL_STRIDE = 8'h10;
    localparam logic [7:0] SYN_LO_OFFSET = 8'h00;
    localparam logic [7:0] SYN_HI_OFFSET = 8'h04;
    localparam logic [7:0] FAR_LO_OFFSET = 8'h08;
    localparam logic [7:0] FAR_HI_OFFSET = 8'h0C;
    localparam int NUM_LEVELS = 3;

    // feature control register bits
    localparam int FEAT_GRANULE_PROT = 0;
    localparam int FEAT_EXT_PA = 1;
    localparam int FEAT_WIDE_LDST = 2;
    localparam int FEAT_WIDE_STATUS = 3;
    localparam int FEAT_WIDE_ACC = 4;
    localparam int FEAT_RELIABILITY = 5;
    localparam int FEAT_MEM_TAGGING = 6;
    localparam int FEAT_WIDTH = 7;
    localparam logic [6:0] FEAT_RESET = 7'h7F;

    // syndrome low word field positions
    localparam int SYN_VALID_BIT = 24;
    localparam int SYN_SIZE_LSB = 22;
    localparam int SYN_SIGN_BIT = 21;
    localparam int SYN_FNV_BIT = 10;
    localparam int SYN_S1WALK_BIT = 7;
    localparam int SYN_FSC_LSB = 0;
    localparam int SECOND_SYNDROME_FIELD_WIDTH = 5;

    // status register fields
    localparam int STAT_LEVEL_LSB = 0;
    localparam int STAT_DROP_BIT = 2;
    localparam int STAT_COUNT_LSB = 16;

    // fault status codes
    localparam logic [5:0] FSC_GPF_WALK_LM1 = 6'h23;
    localparam logic [5:0] FSC_GPF_WALK_L0 = 6'h24;
    localparam logic [5:0] FSC_GPF_WALK_L1 = 6'h25;
    localparam logic [5:0] FSC_GPF_WALK_L2 = 6'h26;
    localparam logic [5:0] FSC_GPF_WALK_L3 = 6'h27;
    localparam logic [5:0] FSC_GPF_NOT_WALK = 6'h28;

    // walk level, two's complement on three bits
    localparam logic [2:0] LEVEL_M1 = 3'h7;
    localparam logic [2:0] LEVEL_0 = 3'h0;
    localparam logic [2:0] LEVEL_1 = 3'h1;
    localparam logic [2:0] LEVEL_2 = 3'h2;
    localparam logic [2:0] LEVEL_3 = 3'h3;

    // access sizes
    localparam logic [1:0] SIZE_DOUBLE = 2'h3;

    // target exception levels
    localparam logic [1:0] TARGET_OS = 2'h1;
    localparam logic [1:0] TARGET_HYP = 2'h2;

    // fixed design decision: syndrome valid on external abort during a stage 2 walk
    localparam logic EXT_WALK_SYNDROME_VALID = 1'b0;

    typedef enum logic [1:0]
    {
        WIDE_NONE = 2'b00,
        WIDE_LOAD_STORE = 2'b01,
        WIDE_STORE_STATUS = 2'b10,
        WIDE_STORE_ACC = 2'b11
    } wide_op_t;

    typedef enum logic [1:0]
    {
        FAULT_OTHER = 2'b00,
        FAULT_TRANSLATION = 2'b01,
        FAULT_ACCESS_FLAG = 2'b10,
        FAULT_PERMISSION = 2'b11
    } fault_kind_t;

endpackage : syndrome_pkg

/* File: verilog/fault_code_encoder.sv */
/*
 * fault status code encoder for granule protection faults.
 * assumes the walker gives the lookup level in two's complement on three bits.
 */
`timescale 1ns/100ps
module fault_code_encoder
(
    input wire logic gpf_i,
    input wire logic gpf_on_walk_i,
    input wire logic [2:0] level_i,
    input wire logic ext_pa_i,
    input wire logic [5:0] other_code_i,
    output logic [5:0] code_o
);
    logic [5:0] walk_code;

    always_comb
    begin
        unique case (level_i)
            syndrome_pkg::LEVEL_M1: walk_code = ext_pa_i ? syndrome_pkg::FSC_GPF_WALK_LM1
                                                         : syndrome_pkg::FSC_GPF_WALK_L0;
            syndrome_pkg::LEVEL_0: walk_code = syndrome_pkg::FSC_GPF_WALK_L0;
            syndrome_pkg::LEVEL_1: walk_code = syndrome_pkg::FSC_GPF_WALK_L1;
            syndrome_pkg::LEVEL_2: walk_code = syndrome_pkg::FSC_GPF_WALK_L2;
            syndrome_pkg::LEVEL_3: walk_code = syndrome_pkg::FSC_GPF_WALK_L3;
            // levels 4..6 do not exist; never emit a reserved code
            default: walk_code = syndrome_pkg::FSC_GPF_WALK_L0;
        endcase
    end

    assign code_o = !gpf_i ? other_code_i
                  : gpf_on_walk_i ? walk_code
                  : syndrome_pkg::FSC_GPF_NOT_WALK;

endmodule : fault_code_encoder

/* File: verilog/abort_fault_syndrome_encoder.sv */
/*
 * abort syndrome encoder: on each abort taken it builds the fault status code,
 * syndrome valid, access size, sign extend, second syndrome field and the
 * address-not-valid flag, and stores them with the fault address in the
 * syndrome register of the target level; software reads them over apb.
 * assumes core inputs are synchronous to REF_CLK_I and stable in the cycle
 * ABORT_TAKE_I is high; the apb master follows the usual two-phase protocol.
 */
// Our own choices: register access over APB and the register addresses.
// What this block does
// - level -1 walk fault gives 0b100011
// - walk fault levels 0-3 give 0b100100-0b100111
// - fault off any walk gives 0b101000
// - only defined status codes are ever emitted
// - stage-one-walk faults use the stage 2 level
// - stage-one-walk flag marks stage 2 on stage 1 walk
// - bit 24 valid; bits 23-14 zero when clear
// - status store variants carry second field 36-32
// - wide load/store faults set valid at any level
// - hypervisor faults valid only for single register access
// - 32-bit case: no writeback, no program counter
// - debug memory mode makes valid free choice
// - reliability present: external abort gives valid 0
// - otherwise fixed choice for stage 2 walk abort
// - stage 2 abort on stage 1 walk: valid 0
// - tag check fault: address valid, flag 0
// - size field encodes byte to doubleword
// - wide faults force size to doubleword
// - sign extend bit for narrow loads
// - sign extend zero for wide and other operations
// - size and sign zero when valid clear
`timescale 1ns/100ps
module abort_fault_syndrome_encoder
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic ABORT_TAKE_I,
    input wire logic [1:0] TARGET_LEVEL_I,
    input wire logic GPF_I,
    input wire logic GPF_ON_WALK_I,
    input wire logic [2:0] WALK_LEVEL_I,
    input wire logic [2:0] S2_LEVEL_I,
    input wire logic [5:0] OTHER_FAULT_CODE_I,
    input wire logic STAGE2_I,
    input wire logic S1_WALK_I,
    input wire logic S2_WALK_I,
    input wire logic [1:0] FAULT_KIND_I,
    input wire logic EXT_ABORT_I,
    input wire logic TAG_CHECK_I,
    input wire logic FAULT_ADDR_NOT_VALID_I,
    input wire logic [63:0] FAULT_ADDR_I,
    input wire logic [1:0] WIDE_OP_I,
    input wire logic SINGLE_GPR_I,
    input wire logic EXCLUSIVE_I,
    input wire logic WRITEBACK_I,
    input wire logic STATE_32BIT_I,
    input wire logic PC_REG_USED_I,
    input wire logic DEBUG_MEM_MODE_I,
    input wire logic [1:0] ACC_SIZE_I,
    input wire logic IS_LOAD_I,
    input wire logic SIGNED_LOAD_I,
    input wire logic [4:0] SECOND_SYNDROME_I
);
    logic [6:0] feat_q;
    logic [6:0] feat_d;
    logic [1:0] last_level_q;
    logic [1:0] last_level_d;
    logic drop_q;
    logic drop_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [31:0] syn_lo_q [syndrome_pkg::NUM_LEVELS];
    logic [4:0] syn_hi_q [syndrome_pkg::NUM_LEVELS];
    logic [63:0] far_q [syndrome_pkg::NUM_LEVELS];
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    // feature view
    wire f_gpc = feat_q[syndrome_pkg::FEAT_GRANULE_PROT];
    wire f_ext_pa = feat_q[syndrome_pkg::FEAT_EXT_PA];
    wire f_wide = feat_q[syndrome_pkg::FEAT_WIDE_LDST];
    wire f_wide_status = feat_q[syndrome_pkg::FEAT_WIDE_STATUS];
    wire f_wide_acc = feat_q[syndrome_pkg::FEAT_WIDE_ACC];
    wire f_ras = feat_q[syndrome_pkg::FEAT_RELIABILITY];
    wire f_mte = feat_q[syndrome_pkg::FEAT_MEM_TAGGING];

    // fault status code
    wire gpf_seen = GPF_I & f_gpc;
    wire [2:0] code_level = S1_WALK_I ? S2_LEVEL_I : WALK_LEVEL_I;
    wire [5:0] fsc;

    fault_code_encoder u_fault_code_encoder
    (
        .gpf_i(gpf_seen),
        .gpf_on_walk_i(GPF_ON_WALK_I),
        .level_i(code_level),
        .ext_pa_i(f_ext_pa),
        .other_code_i(OTHER_FAULT_CODE_I),
        .code_o(fsc)
    );

    wire s1_walk_flag = STAGE2_I & S1_WALK_I;

    // wide load/store with a translation, access flag or permission fault
    wire tafp = FAULT_KIND_I != syndrome_pkg::FAULT_OTHER;
    wire wide_ls = WIDE_OP_I == syndrome_pkg::WIDE_LOAD_STORE;
    wire wide_st = WIDE_OP_I == syndrome_pkg::WIDE_STORE_STATUS;
    wire wide_sa = WIDE_OP_I == syndrome_pkg::WIDE_STORE_ACC;
    wire wide_status_fault = tafp & ((wide_st & f_wide_status) | (wide_sa & f_wide_acc));
    wire wide_fault = (tafp & wide_ls & f_wide) | wide_status_fault;

    // single register access that may report a syndrome at stage 2
    wire single_ok = SINGLE_GPR_I & ~EXCLUSIVE_I & ~WRITEBACK_I;
    wire pc_block = STATE_32BIT_I & PC_REG_USED_I;
    wire hyp_stage2 = (TARGET_LEVEL_I == syndrome_pkg::TARGET_HYP) & STAGE2_I;
    // debug memory mode may report anything; zero keeps the fields quiet
    wire hyp_single = hyp_stage2 & single_ok & ~pc_block & ~DEBUG_MEM_MODE_I;

    logic syn_valid;

    always_comb
    begin
        // a walk access is never the instruction's own, so this outranks the wide case
        if (s1_walk_flag)
        begin
            syn_valid = 1'b0;
        end
        else if (wide_fault)
        begin
            syn_valid = 1'b1;
        end
        else if (EXT_ABORT_I & f_ras)
        begin
            syn_valid = 1'b0;
        end
        else if (EXT_ABORT_I & S2_WALK_I)
        begin
            syn_valid = syndrome_pkg::EXT_WALK_SYNDROME_VALID;
        end
        else
        begin
            syn_valid = hyp_single;
        end
    end

    // access size and sign extension, zero unless valid
    wire [1:0] acc_size = wide_fault ? syndrome_pkg::SIZE_DOUBLE : ACC_SIZE_I;
    wire narrow_load = IS_LOAD_I & (ACC_SIZE_I != syndrome_pkg::SIZE_DOUBLE);
    wire sign_ext = ~wide_fault & narrow_load & SIGNED_LOAD_I;
    wire [1:0] size_field = syn_valid ? acc_size : 2'h0;
    wire sign_field = syn_valid & sign_ext;

    wire [4:0] second_field = wide_status_fault ? SECOND_SYNDROME_I : 5'h00;
    wire fault_addr_not_valid = (TAG_CHECK_I & f_mte) ? 1'b0 : FAULT_ADDR_NOT_VALID_I;

    logic [31:0] syn_word;

    always_comb
    begin
        syn_word = 32'h0000_0000;
        syn_word[syndrome_pkg::SYN_VALID_BIT] = syn_valid;
        syn_word[syndrome_pkg::SYN_SIZE_LSB +: 2] = size_field;
        syn_word[syndrome_pkg::SYN_SIGN_BIT] = sign_field;
        syn_word[syndrome_pkg::SYN_FNV_BIT] = fault_addr_not_valid;
        syn_word[syndrome_pkg::SYN_S1WALK_BIT] = s1_walk_flag;
        syn_word[syndrome_pkg::SYN_FSC_LSB +: 6] = fsc;
    end

    // level zero is not a target; such an abort sets the sticky drop bit
    wire level_ok = TARGET_LEVEL_I != 2'h0;
    wire take = ABORT_TAKE_I & level_ok;

    genvar g;
    generate
        for (g = 0; g < syndrome_pkg::NUM_LEVELS; g = g + 1)
        begin : g_level
            wire hit = take & (TARGET_LEVEL_I == 2'(g + 1));

            always_ff @(posedge REF_CLK_I or negedge RSTN_I)
            begin
                if (!RSTN_I)
                begin
                    syn_lo_q[g] <= 32'h0000_0000;
                    syn_hi_q[g] <= 5'h00;
                    far_q[g] <= 64'h0000_0000_0000_0000;
                end
                else if (hit)
                begin
                    syn_lo_q[g] <= syn_word;
                    syn_hi_q[g] <= second_field;
                    far_q[g] <= FAULT_ADDR_I;
                end
            end
        end
    endgenerate

    // status
    assign last_level_d = take ? TARGET_LEVEL_I : last_level_q;
    assign drop_d = drop_q | (ABORT_TAKE_I & ~level_ok);
    assign count_d = take ? count_q + 16'h0001 : count_q;

    // apb decode: no wait state, answer registered in the setup cycle
    wire setup = PSEL_I & ~PENABLE_I;
    wire access = PSEL_I & PENABLE_I & pready_q;
    wire [7:0] lvl_base = PADDR_I & 8'hF0;
    wire [7:0] lvl_off = PADDR_I & 8'h0F;
    wire [3:0] lvl_idx = PADDR_I[7:4];
    wire lvl_sel = (lvl_idx >= 4'h1) & (lvl_idx <= 4'(syndrome_pkg::NUM_LEVELS));
    wire [1:0] lvl_n = 2'(lvl_idx - 4'h1);
    wire hit_feat = PADDR_I == syndrome_pkg::FEAT_OFFSET;
    wire hit_stat = PADDR_I == syndrome_pkg::STAT_OFFSET;
    wire hit_lvl = lvl_sel & (lvl_base != 8'h00) & (PADDR_I[1:0] == 2'h0);
    wire mapped = hit_feat | hit_stat | hit_lvl;

    logic [31:0] lvl_rd;
    logic [31:0] stat_rd;

    always_comb
    begin
        lvl_rd = 32'h0000_0000;
        if (lvl_sel)
        begin
            unique case (lvl_off)
                syndrome_pkg::SYN_LO_OFFSET: lvl_rd = syn_lo_q[lvl_n];
                syndrome_pkg::SYN_HI_OFFSET: lvl_rd = {27'h0, syn_hi_q[lvl_n]};
                syndrome_pkg::FAR_LO_OFFSET: lvl_rd = far_q[lvl_n][31:0];
                syndrome_pkg::FAR_HI_OFFSET: lvl_rd = far_q[lvl_n][63:32];
                default: lvl_rd = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        stat_rd = 32'h0000_0000;
        stat_rd[syndrome_pkg::STAT_LEVEL_LSB +: 2] = last_level_q;
        stat_rd[syndrome_pkg::STAT_DROP_BIT] = drop_q;
        stat_rd[syndrome_pkg::STAT_COUNT_LSB +: 16] = count_q;
    end

    wire [31:0] rd_mux = hit_feat ? {25'h0, feat_q}
                       : hit_stat ? stat_rd
                       : hit_lvl ? lvl_rd
                       : 32'h0000_0000;

    assign pready_d = setup;
    assign pslverr_d = setup & ~mapped;
    assign prdata_d = (setup & ~PWRITE_I) ? rd_mux : 32'h0000_0000;

    // writes land only at the completing edge; the feature register steers encoding
    wire wr_feat = access & PWRITE_I & hit_feat;
    assign feat_d = wr_feat ? PWDATA_I[syndrome_pkg::FEAT_WIDTH - 1:0] : feat_q;

    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            feat_q <= syndrome_pkg::FEAT_RESET;
            last_level_q <= 2'h0;
            drop_q <= 1'b0;
            count_q <= 16'h0000;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            feat_q <= feat_d;
            last_level_q <= last_level_d;
            drop_q <= drop_d;
            count_q <= count_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;

endmodule : abort_fault_syndrome_encoder

/* File: bench/syndrome_bus_props.sv */
/*
 apb-side checks for the abort syndrome encoder, bound to its top module.
 assumes aligned apb addresses; level registers sit at 0x10, 0x20 and 0x30.
*/
`timescale 1ns/100ps
module syndrome_bus_props
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O
);
    default clocking dc @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    wire top_hit = (PADDR_I[7:4] == 4'h0) && (PADDR_I[3:2] < 2'h2);
    wire lvl_hit = (PADDR_I[7:6] == 2'h0) && (PADDR_I[5:4] != 2'h0);
    wire rd_done = PSEL_I && PENABLE_I && !PWRITE_I && PREADY_O;
    wire syn_rd = rd_done && lvl_hit && (PADDR_I[3:0] == 4'h0);
    wire second_syndrome_field_rd = rd_done && lvl_hit && (PADDR_I[3:0] == 4'h4);

    chk_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no ready one cycle after setup");
    chk_ready_one_cycle: assert property ($rose(PREADY_O) |-> $past(PSEL_I) && !$past(PENABLE_I) ##1 !PREADY_O)
        else $error("ready without setup or held too long");
    chk_err_unmapped: assert property (PREADY_O && PADDR_I[1:0] == 2'h0 |-> PSLVERR_O == !(top_hit || lvl_hit))
        else $error("error response does not match address map");
    chk_idle_bus_zero: assert property (!PREADY_O |-> PRDATA_O == 32'h0 && !PSLVERR_O)
        else $error("read data or error outside access cycle");
    chk_invalid_syn_zero: assert property (syn_rd && !PRDATA_O[24] |-> PRDATA_O[23:14] == 10'h000)
        else $error("syndrome bits not zero while invalid");
    chk_double_unsigned: assert property (syn_rd && PRDATA_O[23:22] == 2'h3 |-> !PRDATA_O[21])
        else $error("sign extend set on doubleword");
    chk_walk_no_valid: assert property (syn_rd && PRDATA_O[7] |-> !PRDATA_O[24])
        else $error("valid syndrome on stage one walk abort");
    chk_second_width: assert property (second_syndrome_field_rd |-> PRDATA_O[31:5] == 27'h0)
        else $error("second syndrome wider than five bits");
endmodule : syndrome_bus_props

bind abort_fault_syndrome_encoder syndrome_bus_props u_syndrome_bus_props
(
    .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O)
);

/* File: bench/core_abort_source.sv */
/*
 core-side model: one abort pulse per call, with the faulting access attributes.
 assumes the encoder samples the attributes only while take_o is high.
*/
`timescale 1ns/100ps
module core_abort_source
(
    input wire logic clk_i,
    output logic take_o,
    output logic [1:0] target_o,
    output logic gpf_o,
    output logic gpf_walk_o,
    output logic [2:0] walk_lvl_o,
    output logic [2:0] s2_lvl_o,
    output logic [5:0] code_o,
    output logic stage2_o,
    output logic s1_walk_o,
    output logic s2_walk_o,
    output logic [1:0] kind_o,
    output logic ext_o,
    output logic tag_o,
    output logic fnv_o,
    output logic [63:0] addr_o,
    output logic [1:0] wide_o,
    output logic single_o,
    output logic excl_o,
    output logic wb_o,
    output logic a32_o,
    output logic pc_o,
    output logic dbg_o,
    output logic [1:0] size_o,
    output logic load_o,
    output logic signed_o,
    output logic [4:0] second_syndrome_field_o
);
    logic [104:0] f_q = '0;
    initial take_o = 1'h0;
    assign {gpf_o, gpf_walk_o, stage2_o, s1_walk_o, s2_walk_o, ext_o, tag_o, fnv_o, single_o, excl_o, wb_o,
        a32_o, pc_o, dbg_o, load_o, signed_o, target_o, kind_o, wide_o, size_o, walk_lvl_o, s2_lvl_o, code_o,
        second_syndrome_field_o, addr_o} = f_q;

    // attributes are inverted after the pulse: an encoder sampling late sees garbage, not a kind copy
    task automatic fire(input logic gpf = 1'h0, gw = 1'h0, st2 = 1'h0, s1w = 1'h0, s2w = 1'h0, ext = 1'h0,
        tag = 1'h0, fault_addr_not_valid = 1'h0, sg1 = 1'h0, ex = 1'h0, wb = 1'h0, a32 = 1'h0, pc = 1'h0, dbg = 1'h0,
        ld = 1'h0, sgn = 1'h0, input logic [1:0] tl = 2'h1, kind = 2'h0, wide = 2'h0, sz = 2'h0,
        input logic [2:0] lvl = 3'h0, s2l = 3'h0, input logic [5:0] oc = 6'h0F, input logic [4:0] ss = 5'h00,
        input logic [63:0] addr = 64'h0);
        @(posedge clk_i);
        take_o <= 1'h1;
        f_q <= {gpf, gw, st2, s1w, s2w, ext, tag, fault_addr_not_valid, sg1, ex, wb, a32, pc, dbg, ld, sgn, tl, kind, wide, sz,
            lvl, s2l, oc, ss, addr};
        @(posedge clk_i);
        take_o <= 1'h0;
        f_q <= ~f_q;
    endtask : fire
endmodule : core_abort_source

/* File: bench/abort_fault_syndrome_encoder_bench.sv */
/*
 self-checking bench: aborts come from the core model, syndromes are read back over apb.
 assumes the register map and field positions of the syndrome package.
*/
`timescale 1ns/100ps
module abort_fault_syndrome_encoder_bench;
    logic REF_CLK_I = 1'h0;
    logic RSTN_I = 1'h0;
    logic PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0, PREADY_O, PSLVERR_O, err;
    logic [7:0] PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
    logic take_o, gpf_o, gpf_walk_o, stage2_o, s1_walk_o, s2_walk_o, ext_o, tag_o, fnv_o, single_o, excl_o;
    logic wb_o, a32_o, pc_o, dbg_o, load_o, signed_o;
    logic [1:0] target_o, kind_o, wide_o, size_o;
    logic [2:0] walk_lvl_o, s2_lvl_o;
    logic [5:0] code_o;
    logic [4:0] second_syndrome_field_o;
    logic [63:0] addr_o;
    int bad_count = 0;
    int check_count = 0;

    always #2.5 REF_CLK_I = ~REF_CLK_I;

    core_abort_source u_core_abort_source
    (
        .clk_i(REF_CLK_I), .take_o(take_o), .target_o(target_o), .gpf_o(gpf_o), .gpf_walk_o(gpf_walk_o),
        .walk_lvl_o(walk_lvl_o), .s2_lvl_o(s2_lvl_o), .code_o(code_o), .stage2_o(stage2_o), .s1_walk_o(s1_walk_o),
        .s2_walk_o(s2_walk_o), .kind_o(kind_o), .ext_o(ext_o), .tag_o(tag_o), .fnv_o(fnv_o), .addr_o(addr_o),
        .wide_o(wide_o), .single_o(single_o), .excl_o(excl_o), .wb_o(wb_o), .a32_o(a32_o), .pc_o(pc_o),
        .dbg_o(dbg_o), .size_o(size_o), .load_o(load_o), .signed_o(signed_o), .second_syndrome_field_o(second_syndrome_field_o)
    );

    abort_fault_syndrome_encoder u_abort_fault_syndrome_encoder
    (
        .REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
        .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
        .ABORT_TAKE_I(take_o), .TARGET_LEVEL_I(target_o), .GPF_I(gpf_o), .GPF_ON_WALK_I(gpf_walk_o),
        .WALK_LEVEL_I(walk_lvl_o), .S2_LEVEL_I(s2_lvl_o), .OTHER_FAULT_CODE_I(code_o), .STAGE2_I(stage2_o),
        .S1_WALK_I(s1_walk_o), .S2_WALK_I(s2_walk_o), .FAULT_KIND_I(kind_o), .EXT_ABORT_I(ext_o),
        .TAG_CHECK_I(tag_o), .FAULT_ADDR_NOT_VALID_I(fnv_o), .FAULT_ADDR_I(addr_o), .WIDE_OP_I(wide_o),
        .SINGLE_GPR_I(single_o), .EXCLUSIVE_I(excl_o), .WRITEBACK_I(wb_o), .STATE_32BIT_I(a32_o),
        .PC_REG_USED_I(pc_o), .DEBUG_MEM_MODE_I(dbg_o), .ACC_SIZE_I(size_o), .IS_LOAD_I(load_o),
        .SIGNED_LOAD_I(signed_o), .SECOND_SYNDROME_I(second_syndrome_field_o)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] syn(input logic v, input logic [1:0] sz, input logic sg, input logic fault_addr_not_valid,
        input logic s1w, input logic [5:0] fsc);
        return {7'h00, v, sz, sg, 10'h000, fault_addr_not_valid, 2'h0, s1w, 1'h0, fsc};
    endfunction : syn

    // the master waits for ready, then checks it came in the first access cycle; a missing ready is left to the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge REF_CLK_I);
        PSEL_I <= 1'h1;
        PWRITE_I <= wr;
        PADDR_I <= a;
        PWDATA_I <= wd;
        @(posedge REF_CLK_I);
        PENABLE_I <= 1'h1;
        do
        begin
            @(posedge REF_CLK_I);
            n++;
        end
        while (PREADY_O !== 1'h1);
        rd = PRDATA_O;
        err = PSLVERR_O;
        check(32'(n), 32'h1);
        PSEL_I <= 1'h0;
        PENABLE_I <= 1'h0;
    endtask : apb

    task automatic t_regs;
        apb(1'h0, syndrome_pkg::FEAT_OFFSET, 32'h0);
        check(rd, {25'h0, syndrome_pkg::FEAT_RESET});
        apb(1'h1, syndrome_pkg::STAT_OFFSET, 32'hFFFFFFFF);
        apb(1'h0, syndrome_pkg::STAT_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 8'h3C, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 8'h08, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'h1, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask : t_regs

    task automatic t_gpf;
        for (int i = 0; i < 5; i++)
        begin
            u_core_abort_source.fire(.gpf(1'h1), .gw(1'h1), .lvl(3'(i - 1)));
            apb(1'h0, 8'h10, 32'h0);
            check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, syndrome_pkg::FSC_GPF_WALK_LM1 + 6'(i)));
        end
        u_core_abort_source.fire(.gpf(1'h1), .lvl(3'h2));
        apb(1'h0, 8'h10, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, syndrome_pkg::FSC_GPF_NOT_WALK));
        u_core_abort_source.fire(.tl(2'h2), .gpf(1'h1), .gw(1'h1), .st2(1'h1), .s1w(1'h1), .sg1(1'h1), .ld(1'h1),
            .s2l(3'h2));
        apb(1'h0, 8'h20, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h1, syndrome_pkg::FSC_GPF_WALK_L2));
        apb(1'h1, syndrome_pkg::FEAT_OFFSET, 32'h7D);
        u_core_abort_source.fire(.gpf(1'h1), .gw(1'h1), .lvl(3'h7));
        apb(1'h0, 8'h10, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, syndrome_pkg::FSC_GPF_WALK_L0));
        apb(1'h1, syndrome_pkg::FEAT_OFFSET, 32'h7C);
        apb(1'h0, syndrome_pkg::FEAT_OFFSET, 32'h0);
        check(rd, 32'h7C);
        u_core_abort_source.fire(.gpf(1'h1), .oc(6'h11));
        apb(1'h0, 8'h10, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, 6'h11));
        apb(1'h1, syndrome_pkg::FEAT_OFFSET, 32'h7F);
    endtask : t_gpf

    task automatic t_wide;
        logic [1:0] t;
        for (int w = 1; w < 4; w++)
            for (int k = 0; k < 4; k++)
            begin
                t = (k == 0) ? 2'h1 : k[1:0];
                u_core_abort_source.fire(.tl(t), .wide(w[1:0]), .kind(k[1:0]), .sz(2'h1), .ld(1'h1), .sgn(1'h1),
                    .ss(5'h15));
                apb(1'h0, {2'h0, t, 4'h0}, 32'h0);
                check(rd, syn(k != 0, {2{k != 0}}, 1'h0, 1'h0, 1'h0, 6'h0F));
                apb(1'h0, {2'h0, t, 4'h4}, 32'h0);
                check(rd, (w > 1 && k != 0) ? 32'h15 : 32'h0);
            end
        u_core_abort_source.fire(.tl(2'h2), .st2(1'h1), .s1w(1'h1), .wide(2'h1), .kind(2'h1));
        apb(1'h0, 8'h20, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h1, 6'h0F));
    endtask : t_wide

    task automatic t_hyp;
        for (int s = 0; s < 4; s++)
        begin
            u_core_abort_source.fire(.tl(2'h2), .st2(1'h1), .sg1(1'h1), .ld(1'h1), .sgn(1'h1), .sz(s[1:0]));
            apb(1'h0, 8'h20, 32'h0);
            check(rd, syn(1'h1, s[1:0], s != 3, 1'h0, 1'h0, 6'h0F));
        end
        for (int j = 0; j < 6; j++)
        begin
            u_core_abort_source.fire(.tl(2'h2), .st2(1'h1), .sg1(1'h1), .ld(1'h1), .sz(2'h2), .ex(j == 0),
                .wb(j == 1), .a32(j == 2 || j == 5), .pc(j == 2), .dbg(j == 3), .ext(j == 4));
            apb(1'h0, 8'h20, 32'h0);
            check(rd, syn(j == 5, {j == 5, 1'h0}, 1'h0, 1'h0, 1'h0, 6'h0F));
        end
    endtask : t_hyp

    task automatic t_ext_tag;
        apb(1'h1, syndrome_pkg::FEAT_OFFSET, 32'h1F);
        u_core_abort_source.fire(.tl(2'h2), .st2(1'h1), .s2w(1'h1), .ext(1'h1), .sg1(1'h1), .ld(1'h1), .sz(2'h2));
        apb(1'h0, 8'h20, 32'h0);
        check(rd, syn(syndrome_pkg::EXT_WALK_SYNDROME_VALID, {syndrome_pkg::EXT_WALK_SYNDROME_VALID, 1'h0}, 1'h0,
            1'h0, 1'h0, 6'h0F));
        u_core_abort_source.fire(.tl(2'h3), .tag(1'h1), .fault_addr_not_valid(1'h1));
        apb(1'h0, 8'h30, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 6'h0F));
        apb(1'h1, syndrome_pkg::FEAT_OFFSET, 32'h7F);
        u_core_abort_source.fire(.tl(2'h3), .tag(1'h1), .fault_addr_not_valid(1'h1), .addr(64'h0123456789ABCDEF));
        apb(1'h0, 8'h30, 32'h0);
        check(rd, syn(1'h0, 2'h0, 1'h0, 1'h0, 1'h0, 6'h0F));
        apb(1'h0, 8'h38, 32'h0);
        check(rd, 32'h89ABCDEF);
        apb(1'h0, 8'h3C, 32'h0);
        check(rd, 32'h01234567);
        u_core_abort_source.fire(.tl(2'h0));
        apb(1'h0, syndrome_pkg::STAT_OFFSET, 32'h0);
        check(rd, 32'h0023_0007);
    endtask : t_ext_tag

    task automatic give_verdict;
        if (bad_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (8) @(posedge REF_CLK_I);
        RSTN_I <= 1'h1;
        t_regs();
        t_gpf();
        t_wide();
        t_hyp();
        t_ext_tag();
        give_verdict();
    end

    // the whole run needs a few dozen transfers, far below this span
    initial
    begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule : abort_fault_syndrome_encoder_bench
